// *** design/mpps_pkg.sv ***
`default_nettype none
package mpps_pkg;
  // Host register map (register index = byte offset / 2, 16-bit words)
  localparam logic [3:0]  CFG_OFFSET      = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET   = 4'h2;
  localparam int          CORE_PWR_BIT    = 15;
  localparam logic [15:0] CFG_RESET       = 16'h8000;
  localparam int          STAT_LOWPWR_BIT = 0;
  localparam int          STAT_TXACT_BIT  = 1;
  localparam int          STAT_RXACT_BIT  = 2;
  localparam int          STAT_PHYRDY_BIT = 3;
  localparam int          STAT_ISO_BIT    = 4;
  // PHY recovery after isolation is released
  localparam int          CLK_MHZ         = 200;
  localparam int          PHY_SETTLE_MS   = 500;
  localparam int          PHY_SETTLE_CYC  = PHY_SETTLE_MS * CLK_MHZ * 1000;
  localparam int          SETTLE_W        = 27;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } mpps_host_req_t;

  typedef struct packed {
    logic transmitEnableBit;
    logic receiveEnableBit;
    logic phyPowerdownBit;
    logic phyIsolateClr;
  } mpps_ctrl_t;

  typedef enum logic [0:0] {TX_IDLE, TX_SEND} mpps_tx_state_t;
  typedef enum logic [0:0] {RX_IDLE, RX_RECV} mpps_rx_state_t;
  typedef enum logic [1:0] {PHY_ON, PHY_DOWN, PHY_ISOLATED, PHY_SETTLE}
    mpps_phy_state_t;
endpackage
`default_nettype wire

// *** design/mac_phy_power_sequencer.sv ***
// Contract
// - Clearing transmit enable finishes current frame, then starts none.
// - Clearing receive enable finishes current frame, then receiver idles.
// - PHY powerdown bit set puts PHY down and line outputs high impedance.
// - Core power enable zero gates PHY-derived clocks and core clock.
// - Host interface and all registers stay accessible in low power.
// - Core power enable one re-enables PHY-derived clocks and core clock.
// - Powerdown off leaves PHY isolated; clearing isolation needs 500 ms.
// - Transmit enable allows sending, receive enable allows receiving.
`timescale 1ns/1ps
`default_nettype none
module mac_phy_power_sequencer #(
  parameter int PHY_SETTLE_CYCLES = mpps_pkg::PHY_SETTLE_CYC
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire mpps_pkg::mpps_host_req_t hostReq,
  output logic [15:0]                   hostRdata,
  input  wire mpps_pkg::mpps_ctrl_t     ctrl,
  input  wire logic                     txFrameReq,
  input  wire logic                     txFrameDone,
  input  wire logic                     rxFrameStart,
  input  wire logic                     rxFrameEnd,
  output logic                          txActive,
  output logic                          rxActive,
  output logic                          phyClkEn,
  output logic                          coreClkEn,
  output logic                          tpOutEn,
  output logic                          phyIsolated,
  output logic                          phyReady,
  output logic                          lowPower
);

  // ************************************************************
  // Host register port
  // ************************************************************
  logic [15:0] cfg_r, cfg_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [4:0]  statusBits;
  logic        clkEn_r, clkEn_nxt;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  // Always clocked by sys_clk, never gated, so low power keeps it alive
  always_comb
  begin
    cfg_nxt   = cfg_r;
    rdata_nxt = rdata_r;
    clkEn_nxt = cfg_r[mpps_pkg::CORE_PWR_BIT];
    if (hostReq.wr && hit(hostReq.addr, mpps_pkg::CFG_OFFSET))
    begin
      cfg_nxt = hostReq.wdata;
    end
    if (hostReq.rd)
    begin
      if (hit(hostReq.addr, mpps_pkg::CFG_OFFSET))
      begin
        rdata_nxt = cfg_r;
      end
      else if (hit(hostReq.addr, mpps_pkg::STATUS_OFFSET))
      begin
        rdata_nxt = {11'h000, statusBits};
      end
      else
      begin
        rdata_nxt = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_r   <= mpps_pkg::CFG_RESET;
      rdata_r <= 16'h0000;
      clkEn_r <= 1'b1;
    end
    else
    begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
      clkEn_r <= clkEn_nxt;
    end
  end
  a_host_alive: assert property (@(posedge sys_clk)
    disable iff (!rst_n) hostReq.rd && hit(hostReq.addr, mpps_pkg::CFG_OFFSET)
    |=> hostRdata == $past(cfg_r))
    else $error("config read wrong in low power");
  a_clk_gate: assert property (@(posedge sys_clk)
    disable iff (!rst_n) hostReq.wr && hit(hostReq.addr, mpps_pkg::CFG_OFFSET)
    && !hostReq.wdata[mpps_pkg::CORE_PWR_BIT]
    |=> ##1 !coreClkEn && !phyClkEn && lowPower)
    else $error("clocks not gated");
  a_clk_ungate: assert property (@(posedge sys_clk)
    disable iff (!rst_n) hostReq.wr && hit(hostReq.addr, mpps_pkg::CFG_OFFSET)
    && hostReq.wdata[mpps_pkg::CORE_PWR_BIT]
    |=> ##1 coreClkEn && phyClkEn && !lowPower)
    else $error("clocks not restored");

  // ************************************************************
  // Transmit and receive engines
  // ************************************************************
  mpps_pkg::mpps_tx_state_t txState_r, txState_nxt;
  mpps_pkg::mpps_rx_state_t rxState_r, rxState_nxt;

  // Engines freeze while gated; a frame cut by gating resumes later
  always_comb
  begin
    txState_nxt = txState_r;
    rxState_nxt = rxState_r;
    if (clkEn_r)
    begin
      unique case (txState_r)
        mpps_pkg::TX_IDLE:
        begin
          if (txFrameReq && ctrl.transmitEnableBit)
          begin
            txState_nxt = mpps_pkg::TX_SEND;
          end
        end
        mpps_pkg::TX_SEND:
        begin
          if (txFrameDone)
          begin
            txState_nxt = mpps_pkg::TX_IDLE;
          end
        end
      endcase
      unique case (rxState_r)
        mpps_pkg::RX_IDLE:
        begin
          if (rxFrameStart && ctrl.receiveEnableBit)
          begin
            rxState_nxt = mpps_pkg::RX_RECV;
          end
        end
        mpps_pkg::RX_RECV:
        begin
          if (rxFrameEnd)
          begin
            rxState_nxt = mpps_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txState_r <= mpps_pkg::TX_IDLE;
      rxState_r <= mpps_pkg::RX_IDLE;
    end
    else
    begin
      txState_r <= txState_nxt;
      rxState_r <= rxState_nxt;
    end
  end
  a_tx_no_start: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !txActive && !ctrl.transmitEnableBit |=> !txActive)
    else $error("transmit started while disabled");
  a_tx_finish: assert property (@(posedge sys_clk)
    disable iff (!rst_n) txActive && coreClkEn && !txFrameDone |=> txActive)
    else $error("transmit frame abandoned early");
  a_rx_no_start: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !rxActive && !ctrl.receiveEnableBit |=> !rxActive)
    else $error("receive started while disabled");
  a_gated_hold: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !clkEn_r |=> $stable(txState_r) && $stable(rxState_r))
    else $error("engine moved while gated");

  // ************************************************************
  // Internal PHY power state
  // ************************************************************
  mpps_pkg::mpps_phy_state_t phyState_r, phyState_nxt;
  logic [mpps_pkg::SETTLE_W-1:0] settleCnt_r, settleCnt_nxt;

  always_comb
  begin
    phyState_nxt  = phyState_r;
    settleCnt_nxt = settleCnt_r;
    if (ctrl.phyPowerdownBit)
    begin
      phyState_nxt = mpps_pkg::PHY_DOWN;
    end
    else
    begin
      unique case (phyState_r)
        mpps_pkg::PHY_ON:
        begin
        end
        mpps_pkg::PHY_DOWN:
        begin
          phyState_nxt = mpps_pkg::PHY_ISOLATED;
        end
        mpps_pkg::PHY_ISOLATED:
        begin
          if (ctrl.phyIsolateClr)
          begin
            phyState_nxt  = mpps_pkg::PHY_SETTLE;
            settleCnt_nxt = PHY_SETTLE_CYCLES[mpps_pkg::SETTLE_W-1:0] - 1'b1;
          end
        end
        mpps_pkg::PHY_SETTLE:
        begin
          if (settleCnt_r == '0)
          begin
            phyState_nxt = mpps_pkg::PHY_ON;
          end
          else
          begin
            settleCnt_nxt = settleCnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phyState_r  <= mpps_pkg::PHY_ON;
      settleCnt_r <= '0;
    end
    else
    begin
      phyState_r  <= phyState_nxt;
      settleCnt_r <= settleCnt_nxt;
    end
  end
  a_phy_hiz: assert property (@(posedge sys_clk)
    disable iff (!rst_n) ctrl.phyPowerdownBit |=> !tpOutEn && !phyReady)
    else $error("line outputs driven in powerdown");
  a_phy_settle: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    phyIsolated && ctrl.phyIsolateClr && !ctrl.phyPowerdownBit |=> !phyReady)
    else $error("PHY ready before settle time");

  // ************************************************************
  // Registered outputs
  // ************************************************************
  logic [7:0] out_r, out_nxt;

  assign statusBits = {phyState_r == mpps_pkg::PHY_ISOLATED,
                       phyState_r == mpps_pkg::PHY_ON,
                       rxState_r == mpps_pkg::RX_RECV,
                       txState_r == mpps_pkg::TX_SEND,
                       !clkEn_r};

  always_comb
  begin
    out_nxt[0] = txState_nxt == mpps_pkg::TX_SEND;
    out_nxt[1] = rxState_nxt == mpps_pkg::RX_RECV;
    out_nxt[2] = clkEn_nxt;
    out_nxt[3] = clkEn_nxt;
    out_nxt[4] = phyState_nxt != mpps_pkg::PHY_DOWN;
    out_nxt[5] = phyState_nxt == mpps_pkg::PHY_ISOLATED;
    out_nxt[6] = phyState_nxt == mpps_pkg::PHY_ON;
    out_nxt[7] = !clkEn_nxt;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_r <= 8'h5c;
    end
    else
    begin
      out_r <= out_nxt;
    end
  end

  assign hostRdata   = rdata_r;
  assign txActive    = out_r[0];
  assign rxActive    = out_r[1];
  assign phyClkEn    = out_r[2];
  assign coreClkEn   = out_r[3];
  assign tpOutEn     = out_r[4];
  assign phyIsolated = out_r[5];
  assign phyReady    = out_r[6];
  assign lowPower    = out_r[7];
endmodule
`default_nettype wire

// *** test/mpps_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpps_host_model (
  input  wire logic                    sys_clk,
  output var mpps_pkg::mpps_host_req_t hostReq,
  input  wire logic [15:0]             hostRdata
);
  initial hostReq = '0;

  // Register cycles for the driver sequence
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    hostReq.addr = a;
    hostReq.wdata = d;
    hostReq.wr = 1'b1;
    @(posedge sys_clk);
    #1;
    hostReq.wr = 1'b0;
    // Released data must not look valid
    hostReq.wdata = ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    #1;
    hostReq.addr = a;
    hostReq.rd = 1'b1;
    @(posedge sys_clk);
    #1;
    hostReq.rd = 1'b0;
    @(posedge sys_clk);
    #1;
    d = hostRdata;
  endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SETTLE = 10;
  logic                     sys_clk;
  logic                     rst_n;
  mpps_pkg::mpps_host_req_t hostReq;
  mpps_pkg::mpps_ctrl_t     ctrl;
  logic [15:0]              hostRdata;
  logic [15:0]              rdv;
  logic [15:0]              v;
  logic txFrameReq, txFrameDone, rxFrameStart, rxFrameEnd;
  logic txActive, rxActive, phyClkEn, coreClkEn;
  logic tpOutEn, phyIsolated, phyReady, lowPower;
  int   n_mismatch;
  int   samples_checked;

  mac_phy_power_sequencer #(.PHY_SETTLE_CYCLES(SETTLE))
    mac_phy_power_sequencer_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .hostReq(hostReq), .hostRdata(hostRdata), .ctrl(ctrl),
    .txFrameReq(txFrameReq), .txFrameDone(txFrameDone),
    .rxFrameStart(rxFrameStart), .rxFrameEnd(rxFrameEnd),
    .txActive(txActive), .rxActive(rxActive), .phyClkEn(phyClkEn),
    .coreClkEn(coreClkEn), .tpOutEn(tpOutEn),
    .phyIsolated(phyIsolated), .phyReady(phyReady),
    .lowPower(lowPower));
  mpps_host_model mpps_host_model_i (.sys_clk(sys_clk),
    .hostReq(hostReq), .hostRdata(hostRdata));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Power flags: tpOut, isolated, ready, lowPower, coreClk, phyClk
  function automatic logic [15:0] pwr();
    return {10'h0, tpOutEn, phyIsolated, phyReady, lowPower,
      coreClkEn, phyClkEn};
  endfunction

  function automatic logic [15:0] busy(bit rx);
    return {15'h0, rx ? rxActive : txActive};
  endfunction

  // One frame; dropEn clears the enable while it is on the wire
  task automatic frame(bit rx, bit dropEn);
    ctrl.transmitEnableBit = !rx | ctrl.transmitEnableBit;
    ctrl.receiveEnableBit = rx | ctrl.receiveEnableBit;
    rxFrameStart = rx;
    txFrameReq = !rx;
    tick(1);
    rxFrameStart = 1'b0;
    txFrameReq = 1'b0;
    check("busy", busy(rx), 16'h1);
    if (dropEn)
    begin
      ctrl.transmitEnableBit = 1'b0;
      ctrl.receiveEnableBit = 1'b0;
    end
    tick($urandom_range(6, 1));
    check("busy_hold", busy(rx), 16'h1);
    rxFrameEnd = rx;
    txFrameDone = !rx;
    tick(1);
    rxFrameEnd = 1'b0;
    txFrameDone = 1'b0;
    check("busy_end", busy(rx), 16'h0);
    if (dropEn)
    begin
      rxFrameStart = rx;
      txFrameReq = !rx;
      tick(3);
      rxFrameStart = 1'b0;
      txFrameReq = 1'b0;
      check("no_start", busy(rx), 16'h0);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    {n_mismatch, samples_checked} = '0;
    rst_n = 1'b0;
    ctrl = '0;
    {txFrameReq, txFrameDone, rxFrameStart, rxFrameEnd} = '0;
    void'($urandom(32'h8202));
    tick(8);
    rst_n = 1'b1;
    check("pwr_rst", pwr(), 16'h002b);
    mpps_host_model_i.rd(mpps_pkg::CFG_OFFSET, rdv);
    check("cfg_rst", rdv, mpps_pkg::CFG_RESET);
    mpps_host_model_i.rd(4'h7, rdv);
    check("unmapped", rdv, 16'h0);
    repeat (4)
    begin
      v = 16'($urandom()) | 16'h8000;
      mpps_host_model_i.wr(mpps_pkg::CFG_OFFSET, v);
      mpps_host_model_i.rd(mpps_pkg::CFG_OFFSET, rdv);
      check("cfg_rw", rdv, v);
    end
    mpps_host_model_i.wr(mpps_pkg::CFG_OFFSET, 16'h8000);
    // Drain order: transmit first, then receive
    frame(1'b0, 1'b1);
    frame(1'b1, 1'b1);
    // Powerdown then gate the core
    ctrl.phyPowerdownBit = 1'b1;
    tick(1);
    check("phy_down", pwr() & 16'h0028, 16'h0);
    mpps_host_model_i.wr(mpps_pkg::CFG_OFFSET, 16'h0000);
    tick(1);
    check("gated", pwr(), 16'h0004);
    ctrl.transmitEnableBit = 1'b1;
    txFrameReq = 1'b1;
    tick(3);
    txFrameReq = 1'b0;
    ctrl.transmitEnableBit = 1'b0;
    check("frozen", busy(0), 16'h0);
    mpps_host_model_i.rd(mpps_pkg::STATUS_OFFSET, rdv);
    check("stat_low", rdv, 16'h0001);
    mpps_host_model_i.rd(mpps_pkg::CFG_OFFSET, rdv);
    check("cfg_low", rdv, 16'h0000);
    // Restore sequence
    mpps_host_model_i.wr(mpps_pkg::CFG_OFFSET, 16'h8000);
    tick(1);
    check("ungated", pwr() & 16'h0007, 16'h0003);
    ctrl.phyPowerdownBit = 1'b0;
    tick(1);
    check("iso", pwr() & 16'h0038, 16'h0030);
    tick(4);
    check("iso_hold", pwr() & 16'h0018, 16'h0010);
    ctrl.phyIsolateClr = 1'b1;
    tick(1);
    ctrl.phyIsolateClr = 1'b0;
    check("iso_clr", pwr() & 16'h0018, 16'h0000);
    tick(SETTLE - 1);
    check("settling", pwr() & 16'h0008, 16'h0000);
    tick(1);
    check("ready", pwr() & 16'h0008, 16'h0008);
    frame(1'b0, 1'b0);
    frame(1'b1, 1'b0);
    mpps_host_model_i.wr(mpps_pkg::STATUS_OFFSET, 16'hffff);
    mpps_host_model_i.rd(mpps_pkg::STATUS_OFFSET, rdv);
    check("stat_ro", rdv, 16'h0008);
    report_and_stop();
  end
endmodule
`default_nettype wire
